// ===== core/mci_pkg.sv
// shared constants for the mailbox command link: mailbox layout, codes, host register map
// assumes both ends and the bench import this package
package mci_pkg;

  // =====================================================================
  // mailbox layout
  localparam int         MB_COUNT     = 32;
  localparam int         MB_AW        = 5;
  localparam int         HDR_LEN      = 4;
  localparam logic [7:0] DATA_MAX     = 8'h1c;
  localparam logic [4:0] MB_APP       = 5'h00;
  localparam logic [4:0] MB_CODE      = 5'h01;
  localparam logic [4:0] MB_OFS_LO    = 5'h02;
  localparam logic [4:0] MB_REQ       = 5'h03;
  localparam logic [4:0] MB_DATA      = 5'h04;
  localparam int         FLAG_BIT     = 7;
  localparam int         CODE_HI      = 6;
  localparam int         CODE_LO      = 4;
  localparam int         OFS_HI_BIT   = 3;

  // =====================================================================
  // application identifiers and command codes
  localparam logic [7:0] APP_VERSION  = 8'h00;
  localparam logic [7:0] APP_MAP      = 8'h04;
  localparam logic [7:0] APP_USER_LO  = 8'h0c;
  localparam logic [7:0] APP_USER_HI  = 8'h0d;
  localparam logic [7:0] APP_MODE     = 8'h18;
  localparam logic [7:0] APP_LAST     = 8'h1f;
  localparam logic [2:0] CMD_FIXED    = 3'h0;
  localparam logic [2:0] CMD_CFG_RD   = 3'h1;
  localparam logic [2:0] CMD_CFG_WR   = 3'h2;
  localparam logic [2:0] CMD_STATUS   = 3'h3;
  localparam logic [6:0] NO_ERROR_CODE      = 7'h00;
  localparam logic [6:0] BAD_PARAMETER_CODE = 7'h04;

  // =====================================================================
  // application data sizes
  localparam logic [7:0] VERSION_LEN  = 8'h0c;
  localparam logic [7:0] CFG_LEN      = 8'h08;
  localparam logic [7:0] STATUS_LEN   = 8'h02;
  localparam logic [2:0] MODE_IRQ_BYTE = 3'h0;
  localparam int         MODE_IRQ_BIT = 0;
  // arbitrary identity and version bytes
  localparam logic [95:0] VERSION_BYTES = 96'h0c0b0a09_08070605_04030201;

  // =====================================================================
  // host register map (AXI4-Lite, byte addresses)
  localparam logic [11:0] REG_CMD     = 12'h000;
  localparam logic [11:0] REG_CTRL    = 12'h004;
  localparam logic [11:0] REG_STATUS  = 12'h008;
  localparam logic [11:0] REG_WDATA   = 12'h020;
  localparam logic [11:0] REG_RDATA   = 12'h040;
  localparam int          CMDR_APP_LO = 0;
  localparam int          CMDR_CNT_LO = 8;
  localparam int          CMDR_OFS_LO = 16;
  localparam int          CMDR_CODE_LO = 28;
  localparam int          CTRL_GO_BIT = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

endpackage

// ===== core/mci_link_if.sv
// mailbox link between the command host and the mailbox device
// assumes one clock; every signal changes just after a rising edge of clk_sys
`timescale 1ns/1ps
interface mci_link_if (
  input wire logic clk_sys,
  input wire logic rst_n
);
  logic       sel;
  logic       start;
  logic [7:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic       rd;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq;

  modport dev  (input sel, start, addr, wr, wdata, rd, output rdata, rvalid, irq);
  modport host (output sel, start, addr, wr, wdata, rd, input rdata, rvalid, irq);
endinterface

// ===== core/mci_device.sv
// mailbox device end: 32 byte mailboxes, command interpreter, small application set
// assumes the host keeps the link framing; same clock as the host
`timescale 1ns/1ps

// Summary of operation
// - 32 one-byte mailboxes hold commands and responses
// - pointer advances after every transferred byte
// - start address and pointer wrap modulo 32
// - host writes whole command from mailbox 0
// - host may read any mailbox subset
// - one write then reads per command
// - completion flag is bit 7 of mailbox 1
// - host polls mailbox 1 until flag set
// - interrupt rises with the completion flag
// - mailbox 1 holds code and offset high
// - header layout: id, code, offset, count
// - codes: version, cfg read, cfg write, status
// - offset indexes the application's byte space
// - write commands carry enough data bytes
// - route to application, else return error
// - results placed back into mailboxes
// - mode app 0x18, mapping app 0x04
// - version app returns 12 bytes
// - ids 0x0c-0x0d stay unbound
// - flag written zero, set when done
// - error 0x00 success, 0x04 bad parameter
// - report actual count, clipped to structure
// - ids 0x20-0xff rejected
module mci_device
  import mci_pkg::*;
#(
  parameter logic [95:0] VERSION_INFO = VERSION_BYTES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  mci_link_if.dev          link,
  output logic             busy,
  output logic [15:0]      cmd_total
);

  typedef enum logic [2:0] {S_IDLE = 3'b001, S_EXEC = 3'b010, S_HEAD = 3'b100} dev_state_t;

  logic [7:0]  mem [0:MB_COUNT-1];
  logic [7:0]  cfg [0:15];
  logic        mem_we, cfg_we;
  logic [4:0]  mem_wa;
  logic [3:0]  cfg_wa;
  logic [7:0]  mem_wd, cfg_wd;

  logic [4:0]  ptr_r, ptr_nxt;
  logic        sel_d_r, zero_r, zero_nxt, seen_r, seen_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rvalid_r;

  dev_state_t  st_r, st_nxt;
  logic [7:0]  app_r, app_nxt, req_r, req_nxt, act_r, act_nxt;
  logic [2:0]  code_r, code_nxt;
  logic [11:0] ofs_r, ofs_nxt;
  logic [6:0]  err_r, err_nxt;
  logic [4:0]  idx_r, idx_nxt;
  logic        irq_r, irq_nxt;
  logic [15:0] total_r, total_nxt;

  logic [7:0]  d_app, d_req, d_size, d_room, d_fit, d_act, src_idx, src_byte;
  logic [2:0]  d_code;
  logic [11:0] d_ofs;
  logic        d_app_ok, d_short, d_ok, launch;

  // =====================================================================
  // link side: pointer, frame tracking, read port
  always_comb begin
    ptr_nxt  = ptr_r;
    zero_nxt = zero_r;
    seen_nxt = seen_r;
    cnt_nxt  = cnt_r;
    if (link.start) begin
      ptr_nxt  = link.addr[MB_AW-1:0];
      zero_nxt = (link.addr[MB_AW-1:0] == MB_APP);
      seen_nxt = 1'b0;
      cnt_nxt  = 6'h00;
    end else if (link.wr || link.rd) begin
      ptr_nxt = ptr_r + 5'h01;
    end
    if (link.wr) begin
      seen_nxt = 1'b1;
      if (cnt_r != 6'h3f) begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end
    rdata_nxt = link.rd ? mem[ptr_r] : rdata_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r    <= 5'h00;
      sel_d_r  <= 1'b0;
      zero_r   <= 1'b0;
      seen_r   <= 1'b0;
      cnt_r    <= 6'h00;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      ptr_r    <= ptr_nxt;
      sel_d_r  <= link.sel;
      zero_r   <= zero_nxt;
      seen_r   <= seen_nxt;
      cnt_r    <= cnt_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= link.rd;
    end
  end

  // =====================================================================
  // command decode straight from the header mailboxes
  always_comb begin
    d_app  = mem[MB_APP];
    d_code = mem[MB_CODE][CODE_HI:CODE_LO];
    d_ofs  = {mem[MB_CODE][OFS_HI_BIT:0], mem[MB_OFS_LO]};
    d_req  = mem[MB_REQ];
    d_size = 8'h00;
    case (d_code)
      CMD_FIXED:              if (d_app == APP_VERSION) d_size = VERSION_LEN;
      CMD_CFG_RD, CMD_CFG_WR: if (d_app == APP_MAP || d_app == APP_MODE) d_size = CFG_LEN;
      CMD_STATUS:             if (d_app == APP_MODE) d_size = STATUS_LEN;
      default:                d_size = 8'h00;
    endcase
    d_app_ok = (d_app <= APP_LAST) && !(d_app >= APP_USER_LO && d_app <= APP_USER_HI);
    d_room   = d_size - d_ofs[7:0];
    d_fit    = (d_req < d_room) ? d_req : d_room;
    d_act    = (d_fit > DATA_MAX) ? DATA_MAX : d_fit;
    d_short  = (cnt_r < 6'(HDR_LEN)) ||
               ((d_code == CMD_CFG_WR) && ({3'b000, cnt_r} < (9'(HDR_LEN) + {1'b0, d_act})));
    d_ok     = d_app_ok && (d_size != 8'h00) && (d_ofs < {4'h0, d_size}) && !d_short;
    launch   = sel_d_r && !link.sel && seen_r && zero_r;
  end

  // =====================================================================
  // application data source
  always_comb begin
    src_idx = ofs_r[7:0] + {3'b000, idx_r};
    case (code_r)
      CMD_FIXED:  src_byte = VERSION_INFO[8*src_idx[3:0] +: 8];
      CMD_STATUS: src_byte = src_idx[0] ? total_r[15:8] : total_r[7:0];
      default:    src_byte = cfg[{app_r == APP_MODE, src_idx[2:0]}];
    endcase
  end

  // =====================================================================
  // command sequencer
  always_comb begin
    st_nxt    = st_r;
    app_nxt   = app_r;
    code_nxt  = code_r;
    ofs_nxt   = ofs_r;
    req_nxt   = req_r;
    act_nxt   = act_r;
    err_nxt   = err_r;
    idx_nxt   = idx_r;
    irq_nxt   = irq_r;
    total_nxt = total_r;
    mem_we    = 1'b0;
    mem_wa    = ptr_r;
    mem_wd    = link.wdata;
    cfg_we    = 1'b0;
    cfg_wa    = {app_r == APP_MODE, src_idx[2:0]};
    cfg_wd    = mem[MB_DATA + idx_r];
    case (st_r)
      S_IDLE: begin
        mem_we = link.wr;
        if (launch) begin
          app_nxt  = d_app;
          code_nxt = d_code;
          ofs_nxt  = d_ofs;
          req_nxt  = d_req;
          err_nxt  = d_ok ? NO_ERROR_CODE : BAD_PARAMETER_CODE;
          act_nxt  = d_ok ? d_act : 8'h00;
          irq_nxt  = 1'b0;
          idx_nxt  = 5'h00;
          st_nxt   = (d_ok && d_act != 8'h00) ? S_EXEC : S_HEAD;
        end
      end
      S_EXEC: begin
        if (code_r == CMD_CFG_WR) begin
          cfg_we = 1'b1;
        end else begin
          mem_we = 1'b1;
          mem_wa = MB_DATA + idx_r;
          mem_wd = src_byte;
        end
        idx_nxt = idx_r + 5'h01;
        if ({3'b000, idx_r} == act_r - 8'h01) begin
          idx_nxt = 5'h00;
          st_nxt  = S_HEAD;
        end
      end
      S_HEAD: begin
        mem_we  = 1'b1;
        idx_nxt = idx_r + 5'h01;
        case (idx_r[1:0])
          2'h0:    begin mem_wa = MB_APP;    mem_wd = app_r; end
          2'h1:    begin mem_wa = MB_OFS_LO; mem_wd = act_r; end
          2'h2:    begin mem_wa = MB_REQ;    mem_wd = req_r; end
          default: begin mem_wa = MB_CODE;   mem_wd = {1'b1, err_r}; end
        endcase
        if (idx_r[1:0] == 2'h3) begin
          idx_nxt   = 5'h00;
          st_nxt    = S_IDLE;
          total_nxt = total_r + 16'h0001;
          irq_nxt   = cfg[{1'b1, MODE_IRQ_BYTE}][MODE_IRQ_BIT];
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= S_IDLE;
      app_r   <= 8'h00;
      code_r  <= 3'h0;
      ofs_r   <= 12'h000;
      req_r   <= 8'h00;
      act_r   <= 8'h00;
      err_r   <= 7'h00;
      idx_r   <= 5'h00;
      irq_r   <= 1'b0;
      total_r <= 16'h0000;
    end else begin
      st_r    <= st_nxt;
      app_r   <= app_nxt;
      code_r  <= code_nxt;
      ofs_r   <= ofs_nxt;
      req_r   <= req_nxt;
      act_r   <= act_nxt;
      err_r   <= err_nxt;
      idx_r   <= idx_nxt;
      irq_r   <= irq_nxt;
      total_r <= total_nxt;
    end
  end

  // =====================================================================
  // storage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MB_COUNT; i++) begin
        mem[i] <= 8'h00;
      end
      for (int i = 0; i < 16; i++) begin
        cfg[i] <= 8'h00;
      end
    end else begin
      if (mem_we) begin
        mem[mem_wa] <= mem_wd;
      end
      if (cfg_we) begin
        cfg[cfg_wa] <= cfg_wd;
      end
    end
  end

  assign link.rdata  = rdata_r;
  assign link.rvalid = rvalid_r;
  assign link.irq    = irq_r;
  assign busy        = (st_r != S_IDLE);
  assign cmd_total   = total_r;

endmodule

// ===== core/mci_host.sv
// command host end: AXI4-Lite register slave that runs one mailbox command per go
// assumes the device end on the same clock behind mci_link_if
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mci_host
  import mci_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  mci_link_if.host         link
);

  typedef enum logic [5:0] {H_IDLE = 6'b000001, H_START = 6'b000010, H_WR = 6'b000100,
                            H_RD = 6'b001000, H_WAIT = 6'b010000, H_END = 6'b100000} host_state_t;
  typedef enum logic [2:0] {PH_W = 3'b001, PH_P = 3'b010, PH_R = 3'b100} phase_t;

  logic [7:0]  wbuf_r [0:27];
  logic [7:0]  wbuf_nxt [0:27];
  logic [7:0]  rbuf_r [0:31];
  logic [7:0]  rbuf_nxt [0:31];
  logic [31:0] cmd_r, cmd_nxt;
  logic        aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [11:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        go;

  host_state_t st_r, st_nxt;
  phase_t      ph_r, ph_nxt;
  logic [4:0]  n_r, n_nxt;
  logic [5:0]  total_r, total_nxt;
  logic [7:0]  addr_r, addr_nxt, wdata_r, wdata_nxt, act_r, act_nxt, cnt_clip;
  logic [6:0]  err_r, err_nxt;
  logic        fin_r, fin_nxt, done_r, done_nxt;

  function automatic logic [7:0] tx_byte(input logic [4:0] i);
    case (i)
      5'h00:   tx_byte = cmd_r[CMDR_APP_LO +: 8];
      5'h01:   tx_byte = {1'b0, cmd_r[CMDR_CODE_LO +: 3], cmd_r[CMDR_OFS_LO+8 +: 4]};
      5'h02:   tx_byte = cmd_r[CMDR_OFS_LO +: 8];
      5'h03:   tx_byte = cmd_r[CMDR_CNT_LO +: 8];
      default: tx_byte = wbuf_r[i - MB_DATA];
    endcase
  endfunction

  // =====================================================================
  // AXI4-Lite slave
  always_comb begin
    aw_h_nxt  = aw_h_r;
    awa_nxt   = awa_r;
    w_h_nxt   = w_h_r;
    wd_nxt    = wd_r;
    ws_nxt    = ws_r;
    bv_nxt    = bv_r;
    bresp_nxt = bresp_r;
    cmd_nxt   = cmd_r;
    wbuf_nxt  = wbuf_r;
    go        = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_h_nxt = 1'b1;
      awa_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_h_nxt = 1'b1;
      wd_nxt  = s_axi_wdata;
      ws_nxt  = s_axi_wstrb;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (aw_h_r && w_h_r) begin
      aw_h_nxt  = 1'b0;
      w_h_nxt   = 1'b0;
      bv_nxt    = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awa_r[11:2] == REG_CMD[11:2]) begin
        for (int b = 0; b < 4; b++) begin
          if (ws_r[b]) cmd_nxt[8*b +: 8] = wd_r[8*b +: 8];
        end
      end else if (awa_r[11:2] == REG_CTRL[11:2]) begin
        go = ws_r[0] && wd_r[CTRL_GO_BIT];
      end else if (awa_r[11:5] == REG_WDATA[11:5] && awa_r[4:2] != 3'h7) begin
        for (int b = 0; b < 4; b++) begin
          if (ws_r[b]) wbuf_nxt[{awa_r[4:2], 2'(b)}] = wd_r[8*b +: 8];
        end
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    rv_nxt    = rv_r;
    rd_nxt    = rd_r;
    rresp_nxt = rresp_r;
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_nxt    = 1'b1;
      rresp_nxt = RESP_OKAY;
      rd_nxt    = 32'h0000_0000;
      if (s_axi_araddr[11:2] == REG_CMD[11:2]) begin
        rd_nxt = cmd_r;
      end else if (s_axi_araddr[11:2] == REG_STATUS[11:2]) begin
        rd_nxt = {7'h00, link.irq, act_r, 1'b0, err_r, 6'h00, done_r, st_r != H_IDLE};
      end else if (s_axi_araddr[11:5] == REG_RDATA[11:5]) begin
        for (int b = 0; b < 4; b++) begin
          rd_nxt[8*b +: 8] = rbuf_r[{s_axi_araddr[4:2], 2'(b)}];
        end
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = !aw_h_r && !bv_r;
  assign s_axi_wready  = !w_h_r && !bv_r;
  assign s_axi_arready = !rv_r;

  // =====================================================================
  // link sequencer: write command, poll flag, read back all mailboxes
  always_comb begin
    st_nxt    = st_r;
    ph_nxt    = ph_r;
    n_nxt     = n_r;
    total_nxt = total_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    fin_nxt   = fin_r;
    done_nxt  = done_r;
    err_nxt   = err_r;
    act_nxt   = act_r;
    rbuf_nxt  = rbuf_r;
    cnt_clip  = (cmd_r[CMDR_CNT_LO +: 8] > DATA_MAX) ? DATA_MAX : cmd_r[CMDR_CNT_LO +: 8];
    case (st_r)
      H_IDLE: if (go) begin
        st_nxt    = H_START;
        ph_nxt    = PH_W;
        addr_nxt  = 8'h00;
        done_nxt  = 1'b0;
        total_nxt = 6'(HDR_LEN) +
                    ((cmd_r[CMDR_CODE_LO +: 3] == CMD_CFG_WR) ? cnt_clip[5:0] : 6'h00);
      end
      H_START: begin
        n_nxt     = 5'h00;
        wdata_nxt = tx_byte(5'h00);
        st_nxt    = (ph_r == PH_W) ? H_WR : H_RD;
      end
      H_WR: begin
        if ({1'b0, n_r} == total_r - 6'h01) begin
          st_nxt = H_END;
          ph_nxt = PH_P;
        end else begin
          n_nxt     = n_r + 5'h01;
          wdata_nxt = tx_byte(n_r + 5'h01);
        end
      end
      H_RD: st_nxt = H_WAIT;
      H_WAIT: if (link.rvalid) begin
        if (ph_r == PH_P) begin
          ph_nxt = link.rdata[FLAG_BIT] ? PH_R : PH_P;
          st_nxt = H_END;
        end else begin
          rbuf_nxt[n_r] = link.rdata;
          n_nxt         = n_r + 5'h01;
          st_nxt        = H_RD;
          if (n_r == 5'h1f) begin
            fin_nxt = 1'b1;
            st_nxt  = H_END;
          end
        end
      end
      H_END: begin
        st_nxt   = H_START;
        addr_nxt = (ph_r == PH_P) ? {3'h0, MB_CODE} : {3'h0, MB_APP};
        if (fin_r) begin
          st_nxt   = H_IDLE;
          fin_nxt  = 1'b0;
          done_nxt = 1'b1;
          err_nxt  = rbuf_r[MB_CODE][6:0];
          act_nxt  = rbuf_r[MB_OFS_LO];
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_h_r  <= 1'b0;
      awa_r   <= 12'h000;
      w_h_r   <= 1'b0;
      wd_r    <= 32'h0000_0000;
      ws_r    <= 4'h0;
      bv_r    <= 1'b0;
      bresp_r <= RESP_OKAY;
      rv_r    <= 1'b0;
      rd_r    <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      cmd_r   <= 32'h0000_0000;
      st_r    <= H_IDLE;
      ph_r    <= PH_W;
      n_r     <= 5'h00;
      total_r <= 6'h00;
      addr_r  <= 8'h00;
      wdata_r <= 8'h00;
      fin_r   <= 1'b0;
      done_r  <= 1'b0;
      err_r   <= 7'h00;
      act_r   <= 8'h00;
      for (int i = 0; i < 28; i++) wbuf_r[i] <= 8'h00;
      for (int i = 0; i < 32; i++) rbuf_r[i] <= 8'h00;
    end else begin
      aw_h_r  <= aw_h_nxt;
      awa_r   <= awa_nxt;
      w_h_r   <= w_h_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      bv_r    <= bv_nxt;
      bresp_r <= bresp_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      rresp_r <= rresp_nxt;
      cmd_r   <= cmd_nxt;
      st_r    <= st_nxt;
      ph_r    <= ph_nxt;
      n_r     <= n_nxt;
      total_r <= total_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      fin_r   <= fin_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      act_r   <= act_nxt;
      wbuf_r  <= wbuf_nxt;
      rbuf_r  <= rbuf_nxt;
    end
  end

  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata  = rd_r;
  assign s_axi_rresp  = rresp_r;
  assign link.sel     = (st_r != H_IDLE) && (st_r != H_END);
  assign link.start   = (st_r == H_START);
  assign link.addr    = addr_r;
  assign link.wr      = (st_r == H_WR);
  assign link.wdata   = wdata_r;
  assign link.rd      = (st_r == H_RD);

endmodule

// ===== bench/mci_link_monitor.sv
// link monitor: framing, strobe and completion-flag checks on the mailbox link
// assumes the signals of the one interface joining host and device
`timescale 1ns/1ps
module mci_link_monitor
  import mci_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       sel,
  input wire logic       start,
  input wire logic [7:0] addr,
  input wire logic       wr,
  input wire logic [7:0] wdata,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq
);
  // ==========================================================
  // helper: mailbox pointer and frame start
  logic [4:0] ptr_r, ptr_nxt, base_r, base_nxt;
  always_comb begin
    ptr_nxt  = ptr_r;
    base_nxt = base_r;
    if (start) begin
      ptr_nxt  = addr[4:0];
      base_nxt = addr[4:0];
    end else if (wr || rd) begin
      ptr_nxt = ptr_r + 5'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r  <= 5'h00;
      base_r <= 5'h00;
    end else begin
      ptr_r  <= ptr_nxt;
      base_r <= base_nxt;
    end
  end
  // ==========================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence rd_reply;
    ##1 rvalid;
  endsequence
  rd_answer_a: assert property (rd |-> rd_reply)
    else $error("read strobe not answered next cycle");
  rvalid_cause_a: assert property (rvalid |-> $past(rd))
    else $error("read reply without read strobe");
  start_alone_a: assert property (start |-> sel && !wr && !rd)
    else $error("frame start not alone");
  frame_start_a: assert property ($rose(sel) |-> start)
    else $error("frame opened without start");
  frame_gap_a: assert property (start |-> !$past(sel))
    else $error("frames not separated");
  strobe_excl_a: assert property ((wr || rd) |-> sel && !(wr && rd))
    else $error("byte strobe outside frame or doubled");
  cmd_origin_a: assert property (wr |-> base_r == MB_APP)
    else $error("write in frame not starting at mailbox 0");
  flag_zero_a: assert property (wr && ptr_r == MB_CODE |-> !wdata[FLAG_BIT])
    else $error("command written with flag set");
  irq_flag_a: assert property (rvalid && $past(ptr_r) == MB_CODE && !rdata[FLAG_BIT]
    |-> !$past(irq))
    else $error("interrupt ahead of completion flag");
endmodule

// ===== bench/mailbox_command_interface_tb_top.sv
// bench top: runs mailbox commands through the host registers, device answers on the link
// assumes the host polls STATUS and keeps the last full readback in RDATA
`timescale 1ns/1ps
module mailbox_command_interface_tb_top
  import mci_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [31:0] st;
  logic [1:0]  rs;
  logic [31:0] bad [6];
  int          fails = 0;
  int          compares = 0;
  always #12.5 clk_sys = ~clk_sys;
  mci_link_if mci_link_if_inst (.clk_sys, .rst_n);
  mci_device mci_device_inst (.clk_sys, .rst_n, .link(mci_link_if_inst), .busy(), .cmd_total());
  mci_host mci_host_inst (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(mci_link_if_inst));
  mci_link_monitor mci_link_monitor_inst (.clk_sys, .rst_n, .sel(mci_link_if_inst.sel),
    .start(mci_link_if_inst.start), .addr(mci_link_if_inst.addr), .wr(mci_link_if_inst.wr),
    .wdata(mci_link_if_inst.wdata), .rd(mci_link_if_inst.rd), .rdata(mci_link_if_inst.rdata),
    .rvalid(mci_link_if_inst.rvalid), .irq(mci_link_if_inst.irq));
  // ==========================================================
  // bus tasks and comparison
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!((ta || !s_axi_awvalid) && (tw || !s_axi_wvalid)));
    do @(negedge clk_sys); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [11:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (!s_axi_rvalid);
    st = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input logic [2:0] c, input logic [11:0] o,
                                     input logic [7:0] n, input logic [7:0] a);
    return {1'b0, c, o, n, a};
  endfunction
  // issue one command, wait for done, check status and response header
  task run(input logic [31:0] c, input logic [6:0] e, input logic [7:0] n);
    axi_wr(REG_CMD, c);
    axi_wr(REG_CTRL, 32'h1);
    st = 32'h0;
    for (int i = 0; i < 400 && st[1] !== 1'b1; i++) axi_rd(REG_STATUS);
    chk({8'h0, st[23:0]}, {8'h0, n, 1'b0, e, 8'h02});
    axi_rd(REG_RDATA);
    chk(st, {c[15:8], n, 1'b1, e, c[7:0]});
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report;
  end
  initial begin
    bad = '{mk(CMD_FIXED, 12'h000, 8'h04, 8'h20), mk(CMD_FIXED, 12'h000, 8'h04, 8'hff),
            mk(CMD_CFG_RD, 12'h000, 8'h01, APP_USER_LO), mk(CMD_FIXED, 12'h000, 8'h01, APP_USER_HI),
            mk(CMD_FIXED, 12'h00c, 8'h01, APP_VERSION), mk(CMD_CFG_RD, 12'h000, 8'h01, APP_VERSION)};
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(REG_STATUS);
    chk(st, 32'h0);
    $display("test reset done");
    run(mk(CMD_FIXED, 12'h000, 8'h0c, APP_VERSION), NO_ERROR_CODE, VERSION_LEN);
    for (int k = 1; k < 4; k++) begin
      axi_rd(REG_RDATA + 12'(4 * k));
      chk(st, VERSION_BYTES[32 * (k - 1) +: 32]);
    end
    run(mk(CMD_FIXED, 12'h00a, 8'h05, APP_VERSION), NO_ERROR_CODE, 8'h02);
    axi_rd(REG_RDATA + 12'h004);
    chk({16'h0, st[15:0]}, {16'h0, VERSION_BYTES[95:80]});
    $display("test version done");
    axi_wr(REG_WDATA, 32'h0000bb01);
    run(mk(CMD_CFG_WR, 12'h000, 8'h02, APP_MODE), NO_ERROR_CODE, 8'h02);
    run(mk(CMD_CFG_RD, 12'h000, 8'h08, APP_MODE), NO_ERROR_CODE, CFG_LEN);
    axi_rd(REG_RDATA + 12'h004);
    chk({16'h0, st[15:0]}, 32'h0000bb01);
    axi_rd(REG_STATUS);
    chk({31'h0, st[24]}, 32'h1);
    axi_wr(REG_WDATA, 32'h0000d0c0);
    run(mk(CMD_CFG_WR, 12'h006, 8'h02, APP_MAP), NO_ERROR_CODE, 8'h02);
    run(mk(CMD_CFG_RD, 12'h000, 8'h08, APP_MAP), NO_ERROR_CODE, CFG_LEN);
    axi_rd(REG_RDATA + 12'h008);
    chk({st[31:16], 16'h0}, 32'hd0c00000);
    run(mk(CMD_STATUS, 12'h000, 8'h02, APP_MODE), NO_ERROR_CODE, STATUS_LEN);
    axi_rd(REG_RDATA + 12'h004);
    chk({16'h0, st[15:0]}, 32'h6);
    $display("test config done");
    foreach (bad[i]) run(bad[i], BAD_PARAMETER_CODE, 8'h00);
    $display("test errors done");
    axi_wr(12'h100, 32'h1);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_rd(12'h100);
    chk({rs, st[29:0]}, {RESP_SLVERR, 30'h0});
    $display("test unmapped done");
    final_report;
  end
endmodule
